// ===== rtl/axis_status_pkg.sv
// Package with parameter numbers, field layouts, reset values and timing constants of the axis status block.
package axis_status_pkg;

   // Parameter numbers used to reach each setting.
   localparam logic [7:0] PNUM_COIL_OPTION = 8'hCC;
   localparam logic [7:0] PNUM_LOAD_VALUE = 8'hCE;
   localparam logic [7:0] PNUM_EXT_ERROR = 8'hCF;
   localparam logic [7:0] PNUM_DRV_FAULT = 8'hD0;
   localparam logic [7:0] PNUM_ENC_COUNT = 8'hD1;
   localparam logic [7:0] PNUM_ENC_RES = 8'hD2;
   localparam logic [7:0] PNUM_DEV_LIMIT = 8'hD4;
   localparam logic [7:0] PNUM_PD_DELAY = 8'hD6;
   localparam logic [7:0] PNUM_UNIT_MODE = 8'hFF;

   // Field widths.
   localparam int COIL_W = 2;
   localparam int LOAD_W = 10;
   localparam int EXT_W = 2;
   localparam int DRV_W = 8;
   localparam int ENC_W = 32;
   localparam int RES_W = 16;
   localparam int DEV_W = 16;
   localparam int PD_W = 9;
   localparam int STILL_W = 21;
   localparam int TICK_W = 20;
   localparam int PIN_N = 9;

   // Reset values and the power-down delay limit.
   localparam logic [PD_W-1:0] PD_DELAY_RESET = 9'h0C8;
   localparam logic UNIT_MODE_RESET = 1'h1;
   localparam logic [PD_W-1:0] PD_DELAY_MAX = 9'h1A1;

   // Extended error code bits.
   localparam int EXT_STALL_BIT = 0;
   localparam int EXT_DEV_BIT = 1;

   // Driver fault word bits; bits 0 to 6 follow the synchronised pin order.
   localparam int DRV_STILL_BIT = 7;

   // Synchronised pin positions.
   localparam int PIN_STALL = 0;
   localparam int PIN_OT = 1;
   localparam int PIN_OTPW = 2;
   localparam int PIN_S2G_A = 3;
   localparam int PIN_S2G_B = 4;
   localparam int PIN_OPEN_A = 5;
   localparam int PIN_OPEN_B = 6;
   localparam int PIN_ENC_STEP = 7;
   localparam int PIN_ENC_DIR = 8;

   // Timing: clock rate, power-down tick and standstill window.
   localparam int CLK_HZ = 50_000_000;
   localparam int PD_TICK_MS = 10;
   localparam int PD_TICK_CYCLES = CLK_HZ / 1000 * PD_TICK_MS;
   localparam int STANDSTILL_LOG2 = 20;
   localparam int STANDSTILL_CYCLES = 1 << STANDSTILL_LOG2;

   // Standstill coil options.
   typedef enum logic [COIL_W-1:0] {
      COIL_NORMAL = 2'h0,
      COIL_FREEWHEEL = 2'h1,
      COIL_SHORT_LOW = 2'h2,
      COIL_SHORT_HIGH = 2'h3
   } coil_option_t;

   // Whole state of the block.
   typedef struct packed {
      logic [PIN_N-1:0] sync1;
      logic [PIN_N-1:0] sync2;
      logic enc_step_prev;
      logic [COIL_W-1:0] coil_opt;
      logic [COIL_W-1:0] coil_out;
      logic [LOAD_W-1:0] load;
      logic [EXT_W-1:0] ext_err;
      logic [DRV_W-1:0] drv_word;
      logic [ENC_W-1:0] enc_count;
      logic [RES_W-1:0] enc_res;
      logic [DEV_W-1:0] dev_limit;
      logic [PD_W-1:0] pd_delay;
      logic unit_mode;
      logic [STILL_W-1:0] still_cnt;
      logic still;
      logic [TICK_W-1:0] tick_cnt;
      logic [PD_W-1:0] pd_ticks;
      logic standby;
      logic dev_stop;
      logic rsp_valid;
      logic rsp_error;
      logic [ENC_W-1:0] rsp_data;
   } axis_state_t;

endpackage

// ===== rtl/axis_status.sv
// Per-axis status, protection and standstill parameter block with its command port.
// Command port timing.
// A request is taken on a rising edge that sees cmd_valid and nrst high.
// Its answer stands on rsp_valid, rsp_error and rsp_data for exactly one cycle,
// one edge later, so requests may follow each other on every cycle.
// An unknown number, a write to a read-only number or an oversized
// power-down delay is answered with rsp_error and changes no setting.
// Read data is zero-extended; a write keeps only the low bits it needs.
//
// Pin timing.
// The driver flags and both encoder pins come from outside this clock domain,
// so each passes two flip-flops before any logic reads it.
// A flag change shows in the driver fault word three edges after it occurs.
// An encoder step rise moves the counter three edges later; encoder
// pulses need only stay high and low for one cycle each to be counted.
//
// Timers.
// TICK_CYCLES is the number of clocks in one 10 ms power-down tick and
// STILL_CYCLES the standstill window; a bench may shorten both.
// Both timers restart on every step pulse, so a motor that steps again before
// the power-down delay has run out never reaches standby current.
//
// Standstill coil handling.
// The selected option reaches coil_mode only while the block is in standby
// and the standby current setting is zero; otherwise the coils run normally.
// Reading the option returns the stored value, not the one applied.
//
// Encoder counter.
// A synchronised step rise counts down with the direction pin high and up
// with it low, and the count wraps at the ends of its 32-bit range.
// A write to the counter beats an encoder edge in the same cycle.
//
// Deviation supervision.
// The commanded position and the encoder count are compared every cycle.
// A stop is held until a motion command arrives while the deviation is
// back within the limit; a command given too early leaves the stop set.
//
// Extended error code.
// Events set their bit and a read or a motion command clears the code.
// When an event and a clear meet in one cycle the event wins, so a fault
// that is still present is never lost by a read.
//
// Reset.
// Settings reset to zero apart from a power-down delay of 200 and unit mode 1.
`timescale 1ns/1ps

module axis_status
   import axis_status_pkg::*;
#(
   // Clocks in one power-down tick; 10 ms at 50 MHz by default.
   parameter int TICK_CYCLES = PD_TICK_CYCLES,
   // Clocks without a step pulse before the standstill bit is set.
   parameter int STILL_CYCLES = STANDSTILL_CYCLES
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [7:0] cmd_number,
   input wire logic [axis_status_pkg::ENC_W-1:0] cmd_data,
   input wire logic motion_cmd,
   input wire logic step_pulse,
   input wire logic standby_current_zero,
   input wire logic [axis_status_pkg::ENC_W-1:0] actual_position,
   input wire logic [axis_status_pkg::LOAD_W-1:0] load_value,
   input wire logic pin_stall,
   input wire logic pin_overtemp,
   input wire logic pin_overtemp_warn,
   input wire logic pin_short_a,
   input wire logic pin_short_b,
   input wire logic pin_open_a,
   input wire logic pin_open_b,
   input wire logic pin_enc_step,
   input wire logic pin_enc_dir,
   output logic rsp_valid,
   output logic rsp_error,
   output logic [axis_status_pkg::ENC_W-1:0] rsp_data,
   output logic [axis_status_pkg::COIL_W-1:0] coil_mode,
   output logic standby_active,
   output logic deviation_stop,
   output logic unit_pps
);
   import axis_status_pkg::*;

   // Last counts of the two timers, cut to the counter widths once here.
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
   localparam logic [STILL_W-1:0] STILL_LAST = STILL_W'(STILL_CYCLES - 1);

   axis_state_t q;
   axis_state_t d;

   // Raw pin vector, read only by the first synchroniser stage.
   logic [PIN_N-1:0] pins;
   // Signed difference of commanded position and encoder count.
   logic signed [ENC_W:0] diff;
   // Its magnitude, compared against the limit.
   logic [ENC_W:0] diff_abs;
   // Deviation above a non-zero limit in this cycle.
   logic dev_over;
   // One-cycle pulse on a synchronised encoder step rise.
   logic enc_edge;
   // Read request for the extended error code.
   logic ext_read;

   // Gather the asynchronous pins in synchroniser order.
   assign pins = {pin_enc_dir, pin_enc_step, pin_open_b, pin_open_a, pin_short_b,
                  pin_short_a, pin_overtemp_warn, pin_overtemp, pin_stall};

   // Deviation between commanded position and encoder count, as a magnitude.
   // One extra bit keeps the difference of two full-range counts from wrapping.
   always_comb begin
      diff = $signed({actual_position[ENC_W-1], actual_position}) -
             $signed({q.enc_count[ENC_W-1], q.enc_count});
      diff_abs = diff[ENC_W] ? (ENC_W+1)'(-diff) : diff;
   end

   // Supervision is off entirely with a zero limit.
   assign dev_over = (q.dev_limit != '0) && (diff_abs > {{(ENC_W+1-DEV_W){1'b0}}, q.dev_limit});

   // Encoder step edge is taken from the second synchroniser stage only.
   assign enc_edge = q.sync2[PIN_ENC_STEP] && !q.enc_step_prev;

   // A read of the extended error code clears it afterwards.
   assign ext_read = cmd_valid && !cmd_write && (cmd_number == PNUM_EXT_ERROR);

   // Next-state logic for the whole block.
   always_comb begin
      d = q;

      // Two-stage synchroniser; the first stage feeds only the second.
      // The first stage may settle late after a pin change, so nothing else reads it.
      d.sync1 = pins;
      d.sync2 = q.sync1;
      d.enc_step_prev = q.sync2[PIN_ENC_STEP];

      // Load measurement is sampled every cycle and only ever read.
      d.load = load_value;

      // Driver fault word mirrors the synchronised driver flags.
      // A flag stays set only while its pin does; the word holds no history.
      d.drv_word[PIN_STALL] = q.sync2[PIN_STALL];
      d.drv_word[PIN_OT] = q.sync2[PIN_OT];
      d.drv_word[PIN_OTPW] = q.sync2[PIN_OTPW];
      d.drv_word[PIN_S2G_A] = q.sync2[PIN_S2G_A];
      d.drv_word[PIN_S2G_B] = q.sync2[PIN_S2G_B];
      d.drv_word[PIN_OPEN_A] = q.sync2[PIN_OPEN_A];
      d.drv_word[PIN_OPEN_B] = q.sync2[PIN_OPEN_B];
      d.drv_word[DRV_STILL_BIT] = q.still;

      // Standstill window restarts on every step pulse.
      // The counter stops at its last value, so the bit holds without wrapping.
      if (step_pulse) begin
         d.still_cnt = '0;
         d.still = 1'b0;
      end else if (q.still_cnt == STILL_LAST) begin
         d.still = 1'b1;
      end else begin
         d.still_cnt = q.still_cnt + 1'b1;
      end

      // Power-down timer counts 10 ms ticks of motionless time.
      // Any step pulse returns to full current at once and restarts the wait.
      // The tick count stops at the delay, so a shorter delay written later
      // takes effect at once rather than after a wrap.
      if (step_pulse) begin
         d.tick_cnt = '0;
         d.pd_ticks = '0;
         d.standby = 1'b0;
      end else if (q.pd_ticks >= q.pd_delay) begin
         d.standby = 1'b1;
      end else if (q.tick_cnt == TICK_LAST) begin
         d.tick_cnt = '0;
         d.pd_ticks = q.pd_ticks + 1'b1;
      end else begin
         d.tick_cnt = q.tick_cnt + 1'b1;
      end

      // Standstill coil handling applies only with zero standby current.
      // The applied option lags standby by one cycle, which is harmless at rest.
      if (standby_current_zero && q.standby) begin
         d.coil_out = q.coil_opt;
      end else begin
         d.coil_out = COIL_NORMAL;
      end

      // Encoder counter follows the synchronised step and direction pins.
      // Both pins pass the same two stages, so direction is settled with the step.
      if (enc_edge) begin
         if (q.sync2[PIN_ENC_DIR]) begin
            d.enc_count = q.enc_count - 1'b1;
         end else begin
            d.enc_count = q.enc_count + 1'b1;
         end
      end

      // Deviation stop holds until the next motion command.
      // A motion command while the deviation persists leaves the stop set.
      if (motion_cmd) begin
         d.dev_stop = 1'b0;
      end
      if (dev_over) begin
         d.dev_stop = 1'b1;
      end

      // Extended errors: clear on read or motion command, but a new event wins.
      if (ext_read || motion_cmd) begin
         d.ext_err = '0;
      end
      if (q.sync2[PIN_STALL]) begin
         d.ext_err[EXT_STALL_BIT] = 1'b1;
      end
      if (dev_over) begin
         d.ext_err[EXT_DEV_BIT] = 1'b1;
      end

      // Command port answers every request one cycle later.
      // Answers are rebuilt each cycle, so rsp_data is zero when nothing was asked.
      d.rsp_valid = cmd_valid;
      d.rsp_error = 1'b0;
      d.rsp_data = '0;
      if (cmd_valid) begin
         if (cmd_write) begin
            case (cmd_number)
               PNUM_COIL_OPTION: begin
                  // All four codes are legal, so no value is refused.
                  d.coil_opt = cmd_data[COIL_W-1:0];
               end
               PNUM_ENC_COUNT: begin
                  // Placed after the edge count, so the write wins.
                  d.enc_count = cmd_data;
               end
               PNUM_ENC_RES: begin
                  // Upper bits of the word are ignored.
                  d.enc_res = cmd_data[RES_W-1:0];
               end
               PNUM_DEV_LIMIT: begin
                  // Supervision resumes on the cycle after a non-zero write.
                  d.dev_limit = cmd_data[DEV_W-1:0];
               end
               PNUM_PD_DELAY: begin
                  // Values above the documented range are refused.
                  if (cmd_data > ENC_W'(PD_DELAY_MAX)) begin
                     d.rsp_error = 1'b1;
                  end else begin
                     d.pd_delay = cmd_data[PD_W-1:0];
                  end
               end
               PNUM_UNIT_MODE: begin
                  // Handed to the motion logic through unit_pps.
                  d.unit_mode = cmd_data[0];
               end
               default: begin
                  // Read-only and unknown numbers change nothing.
                  d.rsp_error = 1'b1;
               end
            endcase
         end else begin
            case (cmd_number)
               PNUM_COIL_OPTION: begin
                  // The stored option, whether or not it is applied now.
                  d.rsp_data = ENC_W'(q.coil_opt);
               end
               PNUM_LOAD_VALUE: begin
                  // Latest sample of the load measurement.
                  d.rsp_data = ENC_W'(q.load);
               end
               PNUM_EXT_ERROR: begin
                  // The code as it stood before the clear that this read causes.
                  d.rsp_data = ENC_W'(q.ext_err);
               end
               PNUM_DRV_FAULT: begin
                  // Flags as registered one cycle ago.
                  d.rsp_data = ENC_W'(q.drv_word);
               end
               PNUM_ENC_COUNT: begin
                  // Full count in two's complement.
                  d.rsp_data = q.enc_count;
               end
               PNUM_ENC_RES: begin
                  // Held for the host; no logic here uses it.
                  d.rsp_data = ENC_W'(q.enc_res);
               end
               PNUM_DEV_LIMIT: begin
                  // Zero means supervision is off.
                  d.rsp_data = ENC_W'(q.dev_limit);
               end
               PNUM_PD_DELAY: begin
                  // Delay in power-down ticks.
                  d.rsp_data = ENC_W'(q.pd_delay);
               end
               PNUM_UNIT_MODE: begin
                  // A single bit, zero-extended like every narrow field.
                  d.rsp_data = ENC_W'(q.unit_mode);
               end
               default: begin
                  // Unknown numbers are refused on reads as well.
                  d.rsp_error = 1'b1;
               end
            endcase
         end
      end
   end

   // State register with synchronous reset.
   // Only constants are loaded in reset; settings not named here start at zero.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         q <= '0;
         q.pd_delay <= PD_DELAY_RESET;
         q.unit_mode <= UNIT_MODE_RESET;
      end else begin
         q <= d;
      end
   end

   // Outputs come straight from the state register.
   // No output passes through logic after the flip-flops.
   assign rsp_valid = q.rsp_valid;
   assign rsp_error = q.rsp_error;
   assign rsp_data = q.rsp_data;
   assign coil_mode = q.coil_out;
   assign standby_active = q.standby;
   assign deviation_stop = q.dev_stop;
   assign unit_pps = q.unit_mode;

endmodule

// ===== tb/axis_status_monitor.sv
// Port checker for the axis status block, bound to every instance of it.
`timescale 1ns/1ps
module axis_status_monitor (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [7:0] cmd_number,
   input wire logic [31:0] cmd_data,
   input wire logic motion_cmd,
   input wire logic step_pulse,
   input wire logic standby_current_zero,
   input wire logic pin_stall,
   input wire logic pin_overtemp,
   input wire logic pin_overtemp_warn,
   input wire logic pin_short_a,
   input wire logic pin_short_b,
   input wire logic pin_open_a,
   input wire logic pin_open_b,
   input wire logic rsp_valid,
   input wire logic rsp_error,
   input wire logic [31:0] rsp_data,
   input wire logic [1:0] coil_mode,
   input wire logic standby_active,
   input wire logic deviation_stop,
   input wire logic unit_pps
);
   import axis_status_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   // Slices are copied out so that the sampled-value functions see plain signals.
   logic wr, rd, unit_d;
   logic [15:0] d16;
   logic [6:0] pins;
   assign wr = cmd_valid && cmd_write;
   assign rd = cmd_valid && !cmd_write;
   assign unit_d = cmd_data[0];
   assign d16 = cmd_data[15:0];
   assign pins = {pin_open_b, pin_open_a, pin_short_b, pin_short_a, pin_overtemp_warn, pin_overtemp, pin_stall};
   a_coil_gated: assert property ((!$past(standby_active) || !$past(standby_current_zero)) |-> coil_mode == 2'h0)
      else $error("coil option applied outside zero standby current");
   a_load_ro: assert property (wr && cmd_number == PNUM_LOAD_VALUE |=> rsp_valid && rsp_error)
      else $error("load readout accepted a write");
   a_ext_range: assert property (rd && cmd_number == PNUM_EXT_ERROR |=> rsp_data[31:2] == 30'h0)
      else $error("extended error code out of range");
   a_fault_mirror: assert property (rd && cmd_number == PNUM_DRV_FAULT |=> rsp_data[6:0] == $past(pins, 4))
      else $error("driver fault word does not mirror pins");
   a_res_readback: assert property (wr && cmd_number == PNUM_ENC_RES ##2 rd && cmd_number == PNUM_ENC_RES
      |=> rsp_data == {16'h0, $past(d16, 3)})
      else $error("encoder resolution readback wrong");
   a_stop_holds: assert property (deviation_stop && !motion_cmd |=> deviation_stop)
      else $error("deviation stop released without motion command");
   a_step_wakes: assert property (step_pulse |=> !standby_active)
      else $error("standby held across a step");
   a_delay_refuse: assert property (wr && cmd_number == PNUM_PD_DELAY && cmd_data > 32'h1A1 |=> rsp_error)
      else $error("oversized power-down delay accepted");
   a_unit_write: assert property (wr && cmd_number == PNUM_UNIT_MODE |=> unit_pps == $past(unit_d))
      else $error("unit mode output does not follow write");
   c_standby_short: cover property (standby_active && coil_mode == 2'h2);
   c_dev_stop: cover property ($rose(deviation_stop));
   c_refused: cover property (rsp_valid && rsp_error);
endmodule
bind axis_status axis_status_monitor mon (.*);

// ===== tb/axis_host.sv
// Host model that issues parameter commands and motion commands.
`timescale 1ns/1ps
module axis_host (
   input wire logic mclk,
   output logic cmd_valid,
   output logic cmd_write,
   output logic [7:0] cmd_number,
   output logic [31:0] cmd_data,
   output logic motion_cmd,
   input wire logic rsp_valid,
   input wire logic rsp_error,
   input wire logic [31:0] rsp_data
);
   initial begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_number = 8'h00;
      cmd_data = 32'h0;
      motion_cmd = 1'b0;
   end
   // One request per call; the idle number and data lines get inverted values so stale data is never mistaken for a request.
   task automatic xfer(input logic w, input logic [7:0] n, input logic [31:0] d, output logic [31:0] q, output logic e);
      @(negedge mclk);
      {cmd_valid, cmd_write, cmd_number, cmd_data} = {1'b1, w, n, d};
      @(posedge mclk);
      @(negedge mclk);
      q = rsp_data;
      e = rsp_valid ? rsp_error : 1'bx;
      {cmd_valid, cmd_number, cmd_data} = {1'b0, ~n, ~d};
   endtask
   // A motion command is a single-cycle pulse.
   task automatic motion();
      @(negedge mclk);
      motion_cmd = 1'b1;
      @(negedge mclk);
      motion_cmd = 1'b0;
   endtask
endmodule

// ===== tb/test_axis_status.sv
// Self-checking testbench for the axis status block.
`timescale 1ns/1ps
module test_axis_status;
   import axis_status_pkg::*;
   logic mclk, nrst, step_pulse, standby_current_zero, pin_enc_step, pin_enc_dir, e;
   logic pin_stall, pin_overtemp, pin_overtemp_warn, pin_short_a, pin_short_b, pin_open_a, pin_open_b;
   logic cmd_valid, cmd_write, motion_cmd, rsp_valid, rsp_error, standby_active, deviation_stop, unit_pps;
   logic [7:0] cmd_number;
   logic [31:0] cmd_data, actual_position, rsp_data, q;
   logic [9:0] load_value;
   logic [1:0] coil_mode;
   int err_count = 0;
   int checks_done = 0;
   always #10 mclk = ~mclk;
   // Short counts keep the standby and standstill waits to a few cycles.
   axis_status #(.TICK_CYCLES(4), .STILL_CYCLES(16)) dut (.*);
   axis_host host (.*);
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic rdc(input string nm, input logic [7:0] n, input logic [31:0] x, input logic [31:0] m = '1);
      host.xfer(1'b0, n, 32'h0, q, e);
      chk(nm, q & m, x);
      chk("read refused", {31'h0, e}, 32'h0);
   endtask
   task automatic wrc(input logic [7:0] n, input logic [31:0] d, input logic err);
      host.xfer(1'b1, n, d, q, e);
      chk("write refused", {31'h0, e}, {31'h0, err});
   endtask
   task automatic step();
      @(negedge mclk);
      step_pulse = 1'b1;
      @(negedge mclk);
      step_pulse = 1'b0;
   endtask
   task automatic t_regs();
      rdc("delay", PNUM_PD_DELAY, 32'd200);
      chk("pps", {31'h0, unit_pps}, 32'h1);
      wrc(PNUM_ENC_RES, 32'h0001FFFF, 1'b0);
      rdc("res", PNUM_ENC_RES, 32'hFFFF);
      wrc(PNUM_UNIT_MODE, 32'h0, 1'b0);
      chk("pps", {31'h0, unit_pps}, 32'h0);
      wrc(PNUM_UNIT_MODE, 32'h1, 1'b0);
      wrc(PNUM_LOAD_VALUE, 32'h5, 1'b1);
      rdc("load", PNUM_LOAD_VALUE, 32'h3FF);
      wrc(PNUM_PD_DELAY, 32'd418, 1'b1);
      rdc("delay", PNUM_PD_DELAY, 32'd200);
      wrc(PNUM_PD_DELAY, 32'd417, 1'b0);
      rdc("delay", PNUM_PD_DELAY, 32'd417);
      wrc(8'h00, 32'h0, 1'b1);
      $display("registers test finished");
   endtask
   task automatic t_faults();
      for (int i = 0; i < 7; i++) begin
         {pin_open_b, pin_open_a, pin_short_b, pin_short_a, pin_overtemp_warn, pin_overtemp, pin_stall} = 7'(1 << i);
         cyc(6);
         rdc("fault", PNUM_DRV_FAULT, 32'(1 << i), 32'h7F);
      end
      {pin_open_b, pin_open_a, pin_short_b, pin_short_a, pin_overtemp_warn, pin_overtemp, pin_stall} = 7'h0;
      cyc(6);
      rdc("ext", PNUM_EXT_ERROR, 32'h1);
      rdc("ext", PNUM_EXT_ERROR, 32'h0);
      step();
      cyc(2);
      rdc("still", PNUM_DRV_FAULT, 32'h0, 32'h80);
      cyc(20);
      rdc("still", PNUM_DRV_FAULT, 32'h80, 32'h80);
      $display("faults test finished");
   endtask
   task automatic t_standby();
      wrc(PNUM_PD_DELAY, 32'd2, 1'b0);
      wrc(PNUM_COIL_OPTION, 32'h2, 1'b0);
      standby_current_zero = 1'b1;
      step();
      cyc(4);
      chk("standby", {31'h0, standby_active}, 32'h0);
      cyc(8);
      chk("standby", {31'h0, standby_active}, 32'h1);
      chk("coil", {30'h0, coil_mode}, 32'h2);
      wrc(PNUM_COIL_OPTION, 32'h3, 1'b0);
      cyc(2);
      chk("coil", {30'h0, coil_mode}, 32'h3);
      wrc(PNUM_COIL_OPTION, 32'h1, 1'b0);
      rdc("coil opt", PNUM_COIL_OPTION, 32'h1);
      cyc(2);
      chk("coil", {30'h0, coil_mode}, 32'h1);
      standby_current_zero = 1'b0;
      cyc(2);
      chk("coil", {30'h0, coil_mode}, 32'h0);
      step();
      chk("standby", {31'h0, standby_active}, 32'h0);
      $display("standby test finished");
   endtask
   task automatic t_dev();
      actual_position = 32'd100;
      cyc(4);
      chk("stop", {31'h0, deviation_stop}, 32'h0);
      // Encoder pulses stay four cycles high and low, above the synchroniser's minimum.
      repeat (3) begin
         pin_enc_step = 1'b1;
         cyc(4);
         pin_enc_step = 1'b0;
         cyc(4);
      end
      rdc("enc", PNUM_ENC_COUNT, 32'd3);
      wrc(PNUM_DEV_LIMIT, 32'd50, 1'b0);
      rdc("limit", PNUM_DEV_LIMIT, 32'd50);
      cyc(3);
      chk("stop", {31'h0, deviation_stop}, 32'h1);
      rdc("ext", PNUM_EXT_ERROR, 32'h2);
      host.motion();
      cyc(2);
      chk("stop", {31'h0, deviation_stop}, 32'h1);
      actual_position = 32'd3;
      host.motion();
      cyc(2);
      chk("stop", {31'h0, deviation_stop}, 32'h0);
      rdc("ext", PNUM_EXT_ERROR, 32'h0);
      // A count of 54 against position 3 is one step past the limit; a stall meets it.
      pin_stall = 1'b1;
      wrc(PNUM_ENC_COUNT, 32'd54, 1'b0);
      pin_stall = 1'b0;
      cyc(4);
      chk("stop", {31'h0, deviation_stop}, 32'h1);
      rdc("ext", PNUM_EXT_ERROR, 32'h3);
      // One step down brings the deviation back to the limit itself.
      pin_enc_dir = 1'b1;
      pin_enc_step = 1'b1;
      cyc(4);
      pin_enc_step = 1'b0;
      cyc(4);
      rdc("enc", PNUM_ENC_COUNT, 32'd53);
      host.motion();
      cyc(2);
      chk("stop", {31'h0, deviation_stop}, 32'h0);
      rdc("ext", PNUM_EXT_ERROR, 32'h0);
      $display("deviation test finished");
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      #200us;
      err_count++;
      test_done();
   end
   initial begin
      {mclk, nrst, step_pulse, standby_current_zero, pin_enc_step, pin_enc_dir} = 6'h0;
      {pin_open_b, pin_open_a, pin_short_b, pin_short_a, pin_overtemp_warn, pin_overtemp, pin_stall} = 7'h0;
      actual_position = 32'h0;
      load_value = 10'h3FF;
      cyc(8);
      nrst = 1'b1;
      t_regs();
      t_faults();
      t_standby();
      t_dev();
      test_done();
   end
endmodule
